// ### uart_flow_defs.svh
// register offsets, field positions, reset values and constants of the flow control block
`ifndef UART_FLOW_DEFS_SVH
`define UART_FLOW_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_EFC        6'h00
`define OFS_MODEM_CTRL 6'h04
`define OFS_MODEM_STAT 6'h08
`define OFS_FCR        6'h0c
`define OFS_TX_LEVEL   6'h10
`define OFS_TX_TRIG    6'h14
`define OFS_RX_LEVEL   6'h18
`define OFS_RX_TRIG    6'h1c
`define OFS_INT_STAT   6'h20
`define OFS_INT_MASK   6'h24

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define EFC_AUTO_RX    6
`define EFC_AUTO_TX    7
`define MODEM_CTRL_DTR 0
`define MODEM_CTRL_RTS 1
`define MODEM_PAIR_SEL 2
`define FCR_TBL_LO     6
`define FCR_TBL_HI     7
`define INT_RX_TRG     0
`define INT_TX_TRG     1
`define INT_MODEM      2

// ----------------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------------
`define RST_REG8       8'h00
`define RST_INT        3'h0
`define FIFO_DEPTH     8'h40
`define TBL_D          2'h3
`define NEXT_LVL_STEP  8'h04

`endif

// ### uart_flow_pkg.sv
// types of the flow control block
package uart_flow_pkg;

  // throttle control: not armed, data may flow, remote held off
  typedef enum logic [2:0] {
    THR_IDLE = 3'b001,
    THR_FLOW = 3'b010,
    THR_HOLD = 3'b100
  } throttle_state_t;

endpackage

// ### uart_hw_flow_fifo_levels.sv
// hardware flow control, fifo level counters and trigger interrupts of one uart channel
//
// Operation
// - auto throttle drives pin from rx occupancy
// - throttle pin deasserts at upper level, rx trigger plus offset
// - reassert once occupancy below lower level
// - auto throttle arms only after software assert
// - pair select bit picks request or terminal pin
// - without auto, pin follows software bit
// - auto gate halts transmit while input high
// - pair select bit picks clear or set-ready input
// - both auto enables clear after reset
// - read-only tx level count, 0 to 64
// - tx trigger interrupt when level falls below
// - read-only rx level count, 0 to 64
// - rx trigger interrupt when level rises to
// - status change bits clear, upper show pins
// - table d picks one of 16 hysteresis offsets
// - tables a-c use next level above/below
`timescale 1ns/1ps
`include "uart_flow_defs.svh"

module uart_hw_flow_fifo_levels (
  input  wire logic        clk_i,      // 40 MHz clock
  input  wire logic        rst_i,      // synchronous reset, active high
  input  wire logic        cyc_i,      // wishbone cycle
  input  wire logic        stb_i,      // wishbone strobe
  input  wire logic        we_i,       // wishbone write enable
  input  wire logic [5:0]  adr_i,      // wishbone byte address
  input  wire logic [3:0]  sel_i,      // wishbone byte select
  input  wire logic [31:0] dat_i,      // wishbone write data
  output logic      [31:0] dat_o,      // wishbone read data
  output logic             ack_o,      // wishbone acknowledge
  input  wire logic        tx_push_i,  // character written to tx fifo
  input  wire logic        tx_pop_i,   // character taken from tx fifo
  input  wire logic        rx_push_i,  // character written to rx fifo
  input  wire logic        rx_pop_i,   // character taken from rx fifo
  input  wire logic        cts_n_i,    // clear-to-send pin
  input  wire logic        dsr_n_i,    // data-set-ready pin
  input  wire logic        ri_n_i,     // ring indicator pin
  input  wire logic        cd_n_i,     // carrier detect pin
  output logic             rts_n_o,    // request-to-send pin
  output logic             dtr_n_o,    // data-terminal-ready pin
  output logic             tx_halt_o,  // transmitter must not start a character
  output logic             irq_o       // level interrupt
);

  // --------------------------------------------------------------------------
  // registers and bus decode
  // --------------------------------------------------------------------------
  logic [7:0] efc;
  logic [7:0] modem_control_reg;
  logic [7:0] fcr;
  logic [7:0] tx_cnt;
  logic [7:0] tx_trg;
  logic [7:0] rx_cnt;
  logic [7:0] rx_trg;
  logic [3:0] modem_status_delta;
  logic [3:0] pins_prev;
  logic [2:0] int_stat;
  logic [2:0] int_mask;
  logic [3:0] pins_now;
  logic       bus_req;
  logic       wr_lo;
  logic       rd_modem_status;
  logic [7:0] next_tx_cnt;
  logic [7:0] next_rx_cnt;
  logic [2:0] int_set;
  uart_flow_pkg::throttle_state_t thr_state;
  uart_flow_pkg::throttle_state_t next_thr_state;

  assign bus_req  = cyc_i & stb_i & ~ack_o;
  assign wr_lo    = bus_req & we_i & sel_i[0];
  assign rd_modem_status = bus_req & ~we_i & (adr_i == `OFS_MODEM_STAT);
  // cd, ri, dsr, cts from bit 3 down, asserted reads as one
  assign pins_now = {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      case (adr_i)
        `OFS_EFC:        dat_o <= {24'h00_0000, efc};
        `OFS_MODEM_CTRL: dat_o <= {24'h00_0000, modem_control_reg};
        `OFS_MODEM_STAT: dat_o <= {24'h00_0000, pins_now, modem_status_delta};
        `OFS_FCR:        dat_o <= {24'h00_0000, fcr};
        `OFS_TX_LEVEL:   dat_o <= {24'h00_0000, tx_cnt};
        `OFS_RX_LEVEL:   dat_o <= {24'h00_0000, rx_cnt};
        `OFS_INT_STAT:   dat_o <= {29'h0000_0000, int_stat};
        `OFS_INT_MASK:   dat_o <= {29'h0000_0000, int_mask};
        default:         dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      efc <= `RST_REG8;
      modem_control_reg <= `RST_REG8;
      fcr <= `RST_REG8;
    end else if (wr_lo) begin
      case (adr_i)
        `OFS_EFC: efc <= dat_i[7:0];
        `OFS_MODEM_CTRL: modem_control_reg <= dat_i[7:0];
        `OFS_FCR: fcr <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // trigger registers are write only and read back as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_trg <= `RST_REG8;
      rx_trg <= `RST_REG8;
    end else if (wr_lo && adr_i == `OFS_TX_TRIG) begin
      tx_trg <= dat_i[7:0];
    end else if (wr_lo && adr_i == `OFS_RX_TRIG) begin
      rx_trg <= dat_i[7:0];
    end
  end

  // --------------------------------------------------------------------------
  // fifo level counters
  // --------------------------------------------------------------------------
  function automatic logic [7:0] level_step(input logic [7:0] cnt,
                                            input logic       push,
                                            input logic       pop);
    logic [7:0] r;
    r = cnt;
    if (push && !pop && cnt < `FIFO_DEPTH) begin
      r = cnt + 8'h01;
    end else if (pop && !push && cnt != 8'h00) begin
      r = cnt - 8'h01;
    end
    return r;
  endfunction

  assign next_tx_cnt = level_step(tx_cnt, tx_push_i, tx_pop_i);
  assign next_rx_cnt = level_step(rx_cnt, rx_push_i, rx_pop_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_cnt <= `RST_REG8;
      rx_cnt <= `RST_REG8;
    end else begin
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
    end
  end

  // --------------------------------------------------------------------------
  // modem status change bits
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_prev <= pins_now;
      modem_status_delta <= 4'h0;
    end else begin
      pins_prev <= pins_now;
      // a change in the read cycle is kept
      modem_status_delta <= (rd_modem_status ? 4'h0 : modem_status_delta)
                            | (pins_now ^ pins_prev);
    end
  end

  // --------------------------------------------------------------------------
  // interrupt status and mask
  // --------------------------------------------------------------------------
  assign int_set[`INT_RX_TRG] = rx_cnt < rx_trg && next_rx_cnt >= rx_trg;
  assign int_set[`INT_TX_TRG] = tx_cnt >= tx_trg && next_tx_cnt < tx_trg;
  assign int_set[`INT_MODEM]  = |(pins_now ^ pins_prev);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_stat <= `RST_INT;
    end else if (wr_lo && adr_i == `OFS_INT_STAT) begin
      int_stat <= (int_stat & ~dat_i[2:0]) | int_set;
    end else begin
      int_stat <= int_stat | int_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_mask <= `RST_INT;
    end else if (wr_lo && adr_i == `OFS_INT_MASK) begin
      int_mask <= dat_i[2:0];
    end
  end

  assign irq_o = |(int_stat & int_mask);

  // --------------------------------------------------------------------------
  // receive throttle levels
  // --------------------------------------------------------------------------
  function automatic logic [7:0] hyst_offset(input logic [3:0] code);
    logic [7:0] r;
    case (code)
      4'h0:    r = 8'h00;
      4'h1:    r = 8'h04;
      4'h2:    r = 8'h06;
      4'h3:    r = 8'h08;
      4'h4:    r = 8'h08;
      4'h5:    r = 8'h10;
      4'h6:    r = 8'h18;
      4'h7:    r = 8'h20;
      4'h8:    r = 8'h28;
      4'h9:    r = 8'h2c;
      4'ha:    r = 8'h30;
      4'hb:    r = 8'h34;
      4'hc:    r = 8'h0c;
      4'hd:    r = 8'h14;
      4'he:    r = 8'h1c;
      default: r = 8'h24;
    endcase
    return r;
  endfunction

  logic [7:0] rx_offset;
  logic [8:0] hi_sum;
  logic [7:0] lvl_hi;
  logic [7:0] lvl_lo;
  logic       pair_sel;
  logic       sw_assert;
  logic       gate_in;

  always_comb begin
    if (fcr[`FCR_TBL_HI:`FCR_TBL_LO] == `TBL_D) begin
      rx_offset = hyst_offset(fcr[3:0]);
    end else begin
      rx_offset = `NEXT_LVL_STEP;
    end
  end

  assign hi_sum = {1'b0, rx_trg} + {1'b0, rx_offset};
  assign lvl_hi = hi_sum[8] ? 8'hff : hi_sum[7:0];
  assign lvl_lo = (rx_trg > rx_offset) ? rx_trg - rx_offset : 8'h00;

  // low pair select: request/clear pins, high: terminal/set-ready pins
  assign pair_sel  = modem_control_reg[`MODEM_PAIR_SEL];
  assign sw_assert = pair_sel ? modem_control_reg[`MODEM_CTRL_DTR]
                              : modem_control_reg[`MODEM_CTRL_RTS];
  assign gate_in   = pair_sel ? dsr_n_i : cts_n_i;
  assign tx_halt_o = efc[`EFC_AUTO_TX] & gate_in;

  // --------------------------------------------------------------------------
  // throttle state machine
  // --------------------------------------------------------------------------
  always_comb begin
    next_thr_state = thr_state;
    case (thr_state)
      uart_flow_pkg::THR_IDLE: begin
        if (efc[`EFC_AUTO_RX] && sw_assert) begin
          next_thr_state = uart_flow_pkg::THR_FLOW;
        end
      end
      uart_flow_pkg::THR_FLOW: begin
        if (!efc[`EFC_AUTO_RX]) begin
          next_thr_state = uart_flow_pkg::THR_IDLE;
        end else if (rx_cnt >= lvl_hi) begin
          next_thr_state = uart_flow_pkg::THR_HOLD;
        end
      end
      uart_flow_pkg::THR_HOLD: begin
        if (!efc[`EFC_AUTO_RX]) begin
          next_thr_state = uart_flow_pkg::THR_IDLE;
        end else if (rx_cnt < lvl_lo) begin
          next_thr_state = uart_flow_pkg::THR_FLOW;
        end
      end
      default: next_thr_state = uart_flow_pkg::THR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_state <= uart_flow_pkg::THR_IDLE;
    end else begin
      thr_state <= next_thr_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end else begin
      rts_n_o <= ~modem_control_reg[`MODEM_CTRL_RTS];
      dtr_n_o <= ~modem_control_reg[`MODEM_CTRL_DTR];
      if (thr_state != uart_flow_pkg::THR_IDLE) begin
        if (pair_sel) begin
          dtr_n_o <= thr_state == uart_flow_pkg::THR_HOLD;
        end else begin
          rts_n_o <= thr_state == uart_flow_pkg::THR_HOLD;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fill;
    thr_state == uart_flow_pkg::THR_FLOW && efc[`EFC_AUTO_RX] && rx_cnt >= lvl_hi;
  endsequence

  // the pin register picked its output with the select of the cycle before
  sequence s_held;
    thr_state == uart_flow_pkg::THR_HOLD ##1 ($past(pair_sel) ? dtr_n_o : rts_n_o);
  endsequence

  property p_deassert;
    s_fill |=> s_held;
  endproperty
  a_deassert: assert property (p_deassert) else $error("throttle did not deassert");

  property p_reassert;
    thr_state == uart_flow_pkg::THR_HOLD && efc[`EFC_AUTO_RX] && rx_cnt < lvl_lo
      |=> thr_state == uart_flow_pkg::THR_FLOW;
  endproperty
  a_reassert: assert property (p_reassert) else $error("throttle did not reassert");

  property p_arm;
    thr_state == uart_flow_pkg::THR_IDLE && !sw_assert
      |=> thr_state == uart_flow_pkg::THR_IDLE;
  endproperty
  a_arm: assert property (p_arm) else $error("throttle armed without assert");

  property p_gpo;
    thr_state == uart_flow_pkg::THR_IDLE
      |=> rts_n_o == ~$past(modem_control_reg[`MODEM_CTRL_RTS]);
  endproperty
  a_gpo: assert property (p_gpo) else $error("pin does not follow software");

  property p_gate;
    efc[`EFC_AUTO_TX] && (pair_sel ? dsr_n_i : cts_n_i) |-> tx_halt_o;
  endproperty
  a_gate: assert property (p_gate) else $error("transmit not halted");

  property p_no_gate;
    !efc[`EFC_AUTO_TX] |-> !tx_halt_o;
  endproperty
  a_no_gate: assert property (p_no_gate) else $error("halt while gating off");

  property p_enables_reset;
    @(posedge clk_i) disable iff (1'b0) rst_i |=> efc[7:6] == 2'h0;
  endproperty
  a_enables_reset: assert property (p_enables_reset) else $error("enables not cleared");

  property p_range;
    tx_cnt <= `FIFO_DEPTH && rx_cnt <= `FIFO_DEPTH;
  endproperty
  a_range: assert property (p_range) else $error("level count out of range");

  property p_rx_count;
    rx_push_i && !rx_pop_i && rx_cnt < `FIFO_DEPTH |=> rx_cnt == $past(rx_cnt) + 8'h01;
  endproperty
  a_rx_count: assert property (p_rx_count) else $error("rx count did not rise");

  property p_tx_int;
    tx_cnt == tx_trg && tx_pop_i && !tx_push_i && tx_cnt != 8'h00 |=> int_stat[`INT_TX_TRG];
  endproperty
  a_tx_int: assert property (p_tx_int) else $error("tx trigger interrupt missing");

  property p_rx_int;
    next_rx_cnt == rx_trg && rx_cnt < rx_trg |=> int_stat[`INT_RX_TRG];
  endproperty
  a_rx_int: assert property (p_rx_int) else $error("rx trigger interrupt missing");

  property p_pin_change;
    pins_now != pins_prev |=> modem_status_delta != 4'h0;
  endproperty
  a_pin_change: assert property (p_pin_change) else $error("status change lost");

  property p_hyst;
    fcr[7:6] == `TBL_D && fcr[3:0] == 4'h5 && rx_trg == 8'h14 |-> lvl_hi == 8'h24 && lvl_lo == 8'h04;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis offset wrong");

  property p_next_level;
    fcr[7:6] != `TBL_D && rx_trg == 8'h08 |-> lvl_hi == 8'h0c && lvl_lo == 8'h04;
  endproperty
  a_next_level: assert property (p_next_level) else $error("next level wrong");

endmodule

// ### uart_flow_remote.sv
// remote serial device model driving the channel's modem input pins
`timescale 1ns/1ps

module uart_flow_remote (
  input  wire logic clk_i,       // channel clock
  input  wire logic hold_cts_i,  // remote holds off on the request pair
  input  wire logic hold_dsr_i,  // remote holds off on the terminal pair
  input  wire logic ring_i,      // ring present
  input  wire logic carrier_i,   // carrier present
  output logic      cts_n_o,     // clear-to-send, low = send allowed
  output logic      dsr_n_o,     // data-set-ready, low = send allowed
  output logic      ri_n_o,      // ring indicator, low = ringing
  output logic      cd_n_o       // carrier detect, low = carrier
);
  // ----------------------------------------------------------------------------
  // pin drivers, levels change only on the clock as the channel expects
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    cts_n_o <= hold_cts_i;
    dsr_n_o <= hold_dsr_i;
    ri_n_o  <= ~ring_i;
    cd_n_o  <= ~carrier_i;
  end
endmodule

// ### uart_hw_flow_fifo_levels_tb.sv
// self-checking bench of the flow control and fifo level block
`timescale 1ns/1ps
`include "uart_flow_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end

module uart_hw_flow_fifo_levels_tb;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wdat = 32'h0, dat_o;
  logic [3:0]  st = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic        ack_o, rts_n_o, dtr_n_o, tx_halt_o, irq_o;
  logic        cts_n, dsr_n, ri_n, cd_n;
  logic        h_cts = 0, h_dsr = 0, ring = 0, carr = 1;
  int          failures = 0, checked = 0, cycles = 0;

  uart_hw_flow_fifo_levels DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .tx_push_i(st[3]), .tx_pop_i(st[2]), .rx_push_i(st[1]), .rx_pop_i(st[0]),
    .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n), .cd_n_i(cd_n),
    .rts_n_o(rts_n_o), .dtr_n_o(dtr_n_o), .tx_halt_o(tx_halt_o), .irq_o(irq_o));

  uart_flow_remote remote (.clk_i(clk_i), .hold_cts_i(h_cts), .hold_dsr_i(h_dsr),
    .ring_i(ring), .carrier_i(carr), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
    .ri_n_o(ri_n), .cd_n_o(cd_n));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------------------
  // bus and strobe helpers
  // ----------------------------------------------------------------------------
  task wb(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    wdat <= {24'h0, d};
    // ends when ack_o is seen; only the bench timeout ends a wait for an ack that never comes
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task wr(input logic [5:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task rchk(input logic [5:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK(q, {24'h0, e})
  endtask
  // strobe pattern {tx push, tx pop, rx push, rx pop} held for n cycles
  task strb(input logic [3:0] s, input int n);
    @(posedge clk_i);
    st <= s;
    repeat (n) @(posedge clk_i);
    st <= 4'h0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  // ----------------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------------
  task t_reset;
    `CHK(rts_n_o, 1'b1)
    `CHK(tx_halt_o, 1'b0)
    rchk(`OFS_EFC, 8'h00);
    rchk(`OFS_RX_LEVEL, 8'h00);
    rchk(`OFS_MODEM_STAT, 8'hb0);
    wr(`OFS_TX_LEVEL, 8'h05);
    rchk(`OFS_TX_LEVEL, 8'h00);
    wr(`OFS_TX_TRIG, 8'h33);
    rchk(`OFS_TX_TRIG, 8'h00);
    wr(6'h30, 8'h5a);
    rchk(6'h30, 8'h00);
  endtask

  task t_soft_pins;
    wr(`OFS_MODEM_CTRL, 8'h02);
    #1;
    `CHK({rts_n_o, dtr_n_o}, 2'b01)
    wr(`OFS_MODEM_CTRL, 8'h01);
    #1;
    `CHK({rts_n_o, dtr_n_o}, 2'b10)
    wr(`OFS_MODEM_CTRL, 8'h00);
  endtask

  task t_rx_level;
    wr(`OFS_RX_TRIG, 8'h08);
    wr(`OFS_INT_MASK, 8'h01);
    strb(4'b0010, 7);
    `CHK(irq_o, 1'b0)
    strb(4'b0010, 1);
    `CHK(irq_o, 1'b1)
    rchk(`OFS_INT_STAT, 8'h01);
    wr(`OFS_INT_STAT, 8'h01);
    `CHK(irq_o, 1'b0)
    strb(4'b0011, 2);
    rchk(`OFS_RX_LEVEL, 8'h08);
    strb(4'b0001, 9);
    rchk(`OFS_RX_LEVEL, 8'h00);
  endtask

  task t_tx_level;
    wr(`OFS_TX_TRIG, 8'h10);
    wr(`OFS_INT_MASK, 8'h02);
    strb(4'b1000, 65);
    rchk(`OFS_TX_LEVEL, 8'h40);
    strb(4'b0100, 48);
    `CHK(irq_o, 1'b0)
    strb(4'b0100, 1);
    `CHK(irq_o, 1'b1)
    wr(`OFS_INT_MASK, 8'h00);
    `CHK(irq_o, 1'b0)
    wr(`OFS_INT_STAT, 8'h02);
    strb(4'b1100, 3);
    rchk(`OFS_TX_LEVEL, 8'h0f);
    strb(4'b0100, 15);
  endtask

  task t_throttle;
    wr(`OFS_FCR, 8'h00);
    wr(`OFS_EFC, 8'h40);
    strb(4'b0010, 13);
    `CHK(rts_n_o, 1'b1)
    strb(4'b0001, 13);
    wr(`OFS_MODEM_CTRL, 8'h02);
    strb(4'b0010, 11);
    `CHK(rts_n_o, 1'b0)
    strb(4'b0010, 1);
    `CHK(rts_n_o, 1'b1)
    strb(4'b0001, 8);
    `CHK(rts_n_o, 1'b1)
    strb(4'b0001, 1);
    `CHK(rts_n_o, 1'b0)
    strb(4'b0001, 3);
    wr(`OFS_FCR, 8'hc5);
    wr(`OFS_RX_TRIG, 8'h14);
    wr(`OFS_MODEM_CTRL, 8'h05);
    strb(4'b0010, 35);
    `CHK({rts_n_o, dtr_n_o}, 2'b10)
    strb(4'b0010, 1);
    `CHK({rts_n_o, dtr_n_o}, 2'b11)
    strb(4'b0001, 32);
    `CHK(dtr_n_o, 1'b1)
    strb(4'b0001, 1);
    `CHK(dtr_n_o, 1'b0)
    strb(4'b0001, 3);
    wr(`OFS_EFC, 8'h00);
    wr(`OFS_MODEM_CTRL, 8'h02);
    strb(4'b0010, 40);
    `CHK({rts_n_o, dtr_n_o}, 2'b01)
    strb(4'b0001, 40);
  endtask

  task t_tx_gate;
    logic [31:0] q;
    wr(`OFS_MODEM_CTRL, 8'h00);
    wr(`OFS_EFC, 8'h80);
    @(posedge clk_i);
    h_cts <= 1;
    strb(4'b0000, 1);
    `CHK(tx_halt_o, 1'b1)
    h_cts <= 0;
    h_dsr <= 1;
    strb(4'b0000, 1);
    `CHK(tx_halt_o, 1'b0)
    wr(`OFS_MODEM_CTRL, 8'h04);
    `CHK(tx_halt_o, 1'b1)
    h_dsr <= 0;
    strb(4'b0000, 1);
    `CHK(tx_halt_o, 1'b0)
    wb(1'b0, `OFS_MODEM_STAT, 8'h00, q);
    `CHK(q[7:0], 8'hb3)
    // clear earlier pin-change events so only the carrier loss can raise irq
    wr(`OFS_INT_STAT, 8'h07);
    wr(`OFS_INT_MASK, 8'h04);
    `CHK(irq_o, 1'b0)
    carr <= 0;
    strb(4'b0000, 1);
    `CHK(irq_o, 1'b1)
    wb(1'b0, `OFS_MODEM_STAT, 8'h00, q);
    `CHK(q[7:0], 8'h38)
    rchk(`OFS_MODEM_STAT, 8'h30);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_soft_pins;
    t_rx_level;
    t_tx_level;
    t_throttle;
    t_tx_gate;
    give_verdict;
  end
endmodule
